//--- rtl/ddr_port_consts.vh
// constants for the double-data-rate parallel port: mode codes, lane map, divider counts
// assumes inclusion by bare name from the design file, the checker and the bench
// Functional notes
// R1: mux mode, encoder on: bit8 marks K-character
// R2: mux mode, encoder off: bits 8,9 extend word
// R3: partner holds bit9 low with encoder on
// R4: nibble mode: bit8 is H bits 4/9 or K; the code carries H bits 3/8 there
// R5: independent mode latches with H clock, else B
// R6: nibble/mux: shared rx clock follows reference
// R7: nibble, tolerance fifo off: recovered/10 clock
// R8: per-channel rx clocks; independent mode own data
// R9: nibble per-channel clocks: recovered/10 or reference
// R10: mux mode: G clock inverts shared clock, pairs
// R11: mux: B on rising, A on falling edge
// R12: nibble: low nibble falling, high rising; lanes
// R13: nibble decoded: bit3 is A K-flag rising
// R14: mux: bit8 ninth bit or K-flag
// R15: nibble: bit8 B bits 4/9 or K-flag; the code drives B bits 3/8 there
// R16: rx data changes on both clock edges; in independent mode the code changes it on the falling edge only
// R17: partner aligns H rising, G falling
// R18: mode and coding static while traffic flows
`ifndef DDR_PORT_CONSTS_VH
`define DDR_PORT_CONSTS_VH
// interface mode codes
`define MODE_INDEP 2'h0
`define MODE_NIBBLE 2'h1
`define MODE_MUX 2'h2
// recovered word clock divides by ten: five recovered cycles per half period
`define HALF_DIV 3'h5
`define HALF_DIV_LAST 3'h4
`define CNT_ZERO 3'h0
// word and lane layout
`define WORD_W 10
`define NIB_A_LO 0
`define NIB_B_LO 5
`define KBIT_A 3
`define KBIT_B 8
`define FIFO_DEPTH 8
`define FIFO_AW 3
`endif

//--- rtl/ddr_word_fifo.v
// holds no logic: the receive word fifo module sits in the port file beside its only user
// assumes nothing of its surroundings

//--- rtl/ddr_parallel_data_port.v
// double-data-rate port: G/H transmit bits 8/9 capture and A/B receive lane mapping
// assumes the link clocks are sampled pins; ref_clk is the reference clock
`timescale 1ns/100ps
`include "ddr_port_consts.vh"
module ddr_parallel_data_port (
    // clock and reset
    input wire ref_clk,
    input wire rstn,
    // static configuration, held while traffic flows
    input wire [1:0] if_mode,
    input wire code_en,
    input wire clock_tolerance_fifo,
    // transmit side pins from the partner
    input wire tx_clock_ch_b,
    input wire tx_clock_ch_h,
    input wire [7:0] tx_gh_bus,
    input wire tx_gh_bit8_kind,
    input wire tx_gh_bit9,
    // transmit words toward the coder
    output reg [9:0] tx_word_h,
    output reg tx_k_h,
    output reg tx_h_valid,
    output reg [9:0] tx_word_g,
    output reg tx_k_g,
    output reg tx_g_valid,
    // recovered serial bit clock of channel A/B, sampled
    input wire recovered_clock,
    // received words from the decoder
    input wire rx_in_valid,
    output wire rx_in_ready,
    input wire [9:0] rx_word_a,
    input wire rx_k_a,
    input wire [9:0] rx_word_b,
    input wire rx_k_b,
    // receive pins toward the partner
    output reg rx_clock_ch_h,
    output reg rx_clock_ch_g,
    output reg per_channel_rx_clock_a,
    output reg per_channel_rx_clock_b,
    output reg [7:0] rx_ab_bus,
    output reg rx_ab_bit8_kflag,
    output reg rx_ab_bit9
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    reg [1:0] tcb_q; // tx clock b two stages
    reg [1:0] tch_q; // tx clock h two stages
    reg [1:0] rec_q; // recovered clock two stages
    reg [9:0] txd_s1_q; // tx data first stage
    reg [9:0] txd_q; // tx data second stage
    reg tclk_prev_q; // previous selected tx clock
    reg rec_prev_q; // previous recovered clock
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            // link clocks park high, so the tx clock chains start high and no false edge follows reset
            tcb_q <= 2'h3;
            tch_q <= 2'h3;
            rec_q <= 2'h0;
            txd_s1_q <= 10'h000;
            txd_q <= 10'h000;
        end
        else
        begin
            tcb_q <= {tcb_q[0], tx_clock_ch_b};
            tch_q <= {tch_q[0], tx_clock_ch_h};
            rec_q <= {rec_q[0], recovered_clock};
            txd_s1_q <= {tx_gh_bit9, tx_gh_bit8_kind, tx_gh_bus};
            txd_q <= txd_s1_q;
        end
    end
    // independent mode uses channel H's own clock, others channel B
    // mode is used live: switching mid-period could fake an edge, so it moves only when idle
    wire tclk_sel = (if_mode == `MODE_INDEP) ? tch_q[1] : tcb_q[1]; // R5 R18
    wire tx_rise = tclk_sel && !tclk_prev_q;
    wire tx_fall = !tclk_sel && tclk_prev_q;
    wire rec_rise = rec_q[1] && !rec_prev_q;
    // ------------------------------------------------------------
    // transmit capture of G/H bits 8 and 9
    // ------------------------------------------------------------
    reg [9:0] nib_lo_q; // nibble mode falling-edge lanes of G and H
    reg [9:0] tx_g_hold_q; // mux mode falling-edge word of channel G
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tclk_prev_q <= 1'b1;
            rec_prev_q <= 1'b0;
            nib_lo_q <= 10'h000;
            tx_g_hold_q <= 10'h000;
            tx_word_h <= 10'h000;
            tx_k_h <= 1'b0;
            tx_h_valid <= 1'b0;
            tx_word_g <= 10'h000;
            tx_k_g <= 1'b0;
            tx_g_valid <= 1'b0;
        end
        else
        begin
            tclk_prev_q <= tclk_sel;
            rec_prev_q <= rec_q[1];
            tx_h_valid <= 1'b0;
            tx_g_valid <= 1'b0;
            case (if_mode)
                `MODE_MUX:
                begin
                    // channel G arrives on the falling edge, H on the rising
                    if (tx_fall)
                        tx_g_hold_q <= txd_q; // R17
                    if (tx_rise)
                    begin
                        // bit9 only meaningful with coding bypassed
                        tx_word_h <= code_en ? {2'h0, txd_q[7:0]} : txd_q; // R2 R3
                        tx_k_h <= code_en && txd_q[8]; // R1
                        tx_h_valid <= 1'b1;
                        tx_word_g <= code_en ? {2'h0, tx_g_hold_q[7:0]} : tx_g_hold_q;
                        tx_k_g <= code_en && tx_g_hold_q[8];
                        tx_g_valid <= 1'b1;
                    end
                end
                `MODE_NIBBLE:
                begin
                    // falling edge brings word bits 4:0, G on lanes 4:0 and H on 9:5
                    if (tx_fall)
                        nib_lo_q <= txd_q;
                    if (tx_rise)
                    begin
                        // bit 8 is H word bits 3 and 8; with coding its rising half is the K indicator
                        tx_word_h <= code_en ? {2'h0, txd_q[7:5], nib_lo_q[9:5]} : {txd_q[9:5], nib_lo_q[9:5]}; // R4
                        tx_k_h <= code_en && txd_q[8]; // R4
                        tx_h_valid <= 1'b1;
                        tx_word_g <= code_en ? {2'h0, txd_q[2:0], nib_lo_q[4:0]} : {txd_q[4:0], nib_lo_q[4:0]};
                        tx_k_g <= code_en && txd_q[3];
                        tx_g_valid <= 1'b1;
                    end
                end
                default:
                begin
                    // independent: H clock captures the bits directly
                    if (tx_rise)
                    begin
                        tx_word_h <= code_en ? {2'h0, txd_q[7:0]} : txd_q;
                        tx_k_h <= code_en && txd_q[8];
                        tx_h_valid <= 1'b1;
                    end
                end
            endcase
        end
    end
    // ------------------------------------------------------------
    // receive clock generation
    // ------------------------------------------------------------
    // the reference copy toggles each ref_clk cycle (half rate, sampled model)
    reg ref_copy_q; // buffered reference clock copy
    reg rec_div_q; // recovered clock divided by ten
    reg [2:0] rec_cnt_q; // divider count of recovered edges
    wire use_rec = (if_mode == `MODE_NIBBLE) && !clock_tolerance_fifo; // R7 R9
    wire rx_clk_n = use_rec ? rec_div_q : ref_copy_q; // R6
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ref_copy_q <= 1'b0;
            rec_div_q <= 1'b0;
            rec_cnt_q <= `CNT_ZERO;
        end
        else
        begin
            ref_copy_q <= !ref_copy_q;
            // five recovered edges per half period gives one tenth rate
            if (rec_rise)
            begin
                if (rec_cnt_q == `HALF_DIV_LAST)
                begin
                    rec_cnt_q <= `CNT_ZERO;
                    rec_div_q <= !rec_div_q; // R7
                end
                else
                    rec_cnt_q <= rec_cnt_q + 3'h1;
            end
        end
    end
    // ------------------------------------------------------------
    // receive word fifo, drained on each rx clock period
    // ------------------------------------------------------------
    reg rx_prev_q; // previous rx clock level
    wire rx_rise_n = rx_clk_n && !rx_prev_q;
    wire rx_fall_n = !rx_clk_n && rx_prev_q;
    wire f_valid;
    reg [21:0] cur_q; // word pair being presented
    wire [21:0] f_raw; // fifo head word pair
    // an empty fifo repeats the last pair instead of showing unwritten storage
    wire [21:0] f_data = f_valid ? f_raw : cur_q;
    // a word pair is consumed at the falling edge that opens its period
    wire f_pop = rx_fall_n;
    ddr_word_fifo #(
        .WIDTH(22),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .in_valid(rx_in_valid),
        .in_ready(rx_in_ready),
        .in_data({rx_k_b, rx_word_b, rx_k_a, rx_word_a}),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_raw)
    );
    // ------------------------------------------------------------
    // receive pin drive, both edges of the rx clock in mux and nibble mode, falling edge only in independent mode
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_prev_q <= 1'b0;
            cur_q <= 22'h000000;
            rx_clock_ch_h <= 1'b0;
            rx_clock_ch_g <= 1'b0;
            per_channel_rx_clock_a <= 1'b0;
            per_channel_rx_clock_b <= 1'b0;
            rx_ab_bus <= 8'h00;
            rx_ab_bit8_kflag <= 1'b0;
            rx_ab_bit9 <= 1'b0;
        end
        else
        begin
            rx_prev_q <= rx_clk_n;
            rx_clock_ch_h <= rx_clk_n;
            // mux mode pairs a true and complementary clock
            rx_clock_ch_g <= (if_mode == `MODE_MUX) ? !rx_clk_n : rx_clk_n; // R10 R8
            per_channel_rx_clock_a <= (if_mode == `MODE_MUX) ? !rx_clk_n : rx_clk_n; // R10
            per_channel_rx_clock_b <= rx_clk_n; // R9
            if (rx_fall_n && f_valid)
                cur_q <= f_data;
            // new word pair on falling edge, second half on rising
            if (rx_fall_n || rx_rise_n) // R16
            begin
                case (if_mode)
                    `MODE_MUX:
                    begin
                        if (rx_fall_n)
                        begin
                            // channel A on falling edge
                            rx_ab_bus <= f_data[7:0]; // R11
                            rx_ab_bit8_kflag <= code_en ? f_data[10] : f_data[8]; // R14
                            rx_ab_bit9 <= code_en ? 1'b0 : f_data[9];
                        end
                        else
                        begin
                            // channel B on rising edge
                            rx_ab_bus <= cur_q[18:11]; // R11
                            rx_ab_bit8_kflag <= code_en ? cur_q[21] : cur_q[19]; // R14
                            rx_ab_bit9 <= code_en ? 1'b0 : cur_q[20];
                        end
                    end
                    `MODE_NIBBLE:
                    begin
                        if (rx_fall_n)
                        begin
                            // least-significant nibbles: A on 4:0, B on 9:5
                            rx_ab_bus <= {f_data[13:11], f_data[4:0]}; // R12
                            rx_ab_bit8_kflag <= f_data[14]; // R15
                            rx_ab_bit9 <= f_data[15];
                        end
                        else
                        begin
                            rx_ab_bus[2:0] <= cur_q[7:5]; // R12
                            rx_ab_bus[3] <= code_en ? cur_q[10] : cur_q[8]; // R13
                            rx_ab_bus[4] <= cur_q[9];
                            rx_ab_bus[7:5] <= cur_q[18:16];
                            rx_ab_bit8_kflag <= code_en ? cur_q[21] : cur_q[19]; // R15
                            rx_ab_bit9 <= cur_q[20];
                        end
                    end
                    default:
                    begin
                        // independent: channel A word on its own clock
                        if (rx_fall_n)
                        begin
                            rx_ab_bus <= f_data[7:0]; // R8
                            rx_ab_bit8_kflag <= code_en ? f_data[10] : f_data[8];
                            rx_ab_bit9 <= f_data[9];
                        end
                    end
                endcase
            end
        end
    end
endmodule
// ------------------------------------------------------------
// receive word fifo: one clock, valid/ready on both sides
// ------------------------------------------------------------
module ddr_word_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire ref_clk,
    input wire rstn,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage array
    reg [AW-1:0] wr_q; // write pointer
    reg [AW-1:0] rd_q; // read pointer
    reg [AW:0] cnt_q; // fill level
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rd_q];
    // ------------------------------------------------------------
    // pointer and level tracking
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
    // storage write, no reset needed for data
    always @(posedge ref_clk)
    begin
        if (push)
            mem[wr_q] <= in_data;
    end
endmodule

//--- tb/ddr_port_checker.sv
// checker for the ddr port: receive clock shapes, lane pairing, transmit pulses
// assumes it is bound onto the port top; configuration is held static while traffic flows
`timescale 1ns/100ps
`include "ddr_port_consts.vh"
module ddr_port_checker (
    // clock and reset
    input wire ref_clk,
    input wire rstn,
    // static configuration
    input wire [1:0] if_mode,
    input wire code_en,
    input wire clock_tolerance_fifo,
    // watched outputs
    input wire [9:0] tx_word_h,
    input wire tx_h_valid,
    input wire rx_clock_ch_h,
    input wire rx_clock_ch_g,
    input wire per_channel_rx_clock_a,
    input wire per_channel_rx_clock_b,
    input wire [7:0] rx_ab_bus,
    input wire rx_ab_bit9
);
    // ----
    // settle tracking
    // ----
    reg [3:0] cfg_q; // configuration seen last cycle
    reg [2:0] age_q; // cycles since configuration last moved
    wire settled = (age_q == 3'h7);
    wire mux_s = settled && (if_mode == `MODE_MUX);
    wire nib_s = settled && (if_mode == `MODE_NIBBLE);
    // age restarts on any move, so a mode switch never trips a check
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cfg_q <= 4'h0;
            age_q <= 3'h0;
        end
        else
        begin
            cfg_q <= {if_mode, code_en, clock_tolerance_fifo};
            if ({if_mode, code_en, clock_tolerance_fifo} != cfg_q)
                age_q <= 3'h0;
            else if (!settled)
                age_q <= age_q + 3'h1;
        end
    end
    // ----
    // properties
    // ----
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence rx_half_sq;
        $changed(rx_clock_ch_h);
    endsequence
    sequence hold8_sq;
        $stable(rx_clock_ch_h)[*8];
    endsequence
    mux_clk_pair_a: assert property (mux_s |-> rx_clock_ch_g != rx_clock_ch_h)
        else $error("g clock is not the inverse of the shared clock");
    mux_lane_pair_a: assert property (mux_s |-> per_channel_rx_clock_a != per_channel_rx_clock_b)
        else $error("a and b clocks are not a true and inverse pair");
    ref_copy_a: assert property ((mux_s || (nib_s && clock_tolerance_fifo)) |-> rx_half_sq)
        else $error("shared clock is not following the reference");
    lane_copy_a: assert property ((nib_s && clock_tolerance_fifo) |-> $changed(per_channel_rx_clock_a))
        else $error("lane clock is not following the reference");
    divided_hold_a: assert property ((nib_s && !clock_tolerance_fifo) ##0 rx_half_sq |=> hold8_sq)
        else $error("divided clock half period too short");
    tx_pulse_a: assert property (tx_h_valid |=> !tx_h_valid)
        else $error("transmit valid longer than one cycle");
    tx_word_stand_a: assert property (!tx_h_valid |-> $stable(tx_word_h))
        else $error("transmit word moved without a capture");
    mux_k_only_a: assert property ((mux_s && code_en) |-> rx_ab_bit9 == 1'b0)
        else $error("bit nine driven while decoding");
    rx_edge_only_a: assert property ((nib_s && !clock_tolerance_fifo && $changed(rx_ab_bus)) |-> rx_half_sq)
        else $error("receive data moved away from a clock edge");
endmodule

//--- tb/mac_tx_model.sv
// far-side model: protocol device driving the G/H transmit pins and both transmit clocks
// assumes a 160 ns link period; clocks park high and stand still between frames
`timescale 1ns/100ps
module mac_tx_model (
    // configuration seen by the far side
    input wire code_en,
    // transmit pins
    output reg tx_clock_ch_b,
    output reg tx_clock_ch_h,
    output reg [7:0] tx_gh_bus,
    output reg tx_gh_bit8_kind,
    output reg tx_gh_bit9
);
    // idle level before the first frame
    initial
    begin
        tx_clock_ch_b = 1'b1;
        tx_clock_ch_h = 1'b1;
        {tx_gh_bit9, tx_gh_bit8_kind, tx_gh_bus} = 10'h000;
    end
    // place one value; bit nine sits on its pull-down while the coder is on
    task put(input [9:0] v);
    begin
        tx_gh_bus = v[7:0];
        tx_gh_bit8_kind = v[8];
        tx_gh_bit9 = code_en ? 1'b0 : v[9];
    end
    endtask
    // one frame: g ahead of the falling edge, h ahead of the rising edge
    task frame(input indep, input [9:0] g, input [9:0] h);
    begin
        put(g);
        #20;
        if (indep)
            tx_clock_ch_h = 1'b0;
        else
            tx_clock_ch_b = 1'b0;
        #60;
        put(h);
        #20;
        tx_clock_ch_h = 1'b1;
        tx_clock_ch_b = 1'b1;
        #60;
        // hold time over: every line but bit nine, which stays on its pull-down with the coder on, changes from the old value
        put(~h);
    end
    endtask
endmodule

//--- tb/tb.sv
// bench for the ddr port: transmit capture, receive lane maps, divider and fifo fill
// assumes the checker and the far-side model are compiled ahead of this file
`timescale 1ns/100ps
`include "ddr_port_consts.vh"
module tb;
    // ----
    // signals
    // ----
    reg ref_clk, rstn, code_en, clock_tolerance_fifo, recovered_clock, rx_in_valid, rx_k_a, rx_k_b;
    reg [1:0] if_mode;
    reg [9:0] rx_word_a, rx_word_b;
    reg last, last_a; // previous clock levels while counting
    wire tx_clock_ch_b, tx_clock_ch_h, tx_gh_bit8_kind, tx_gh_bit9, tx_k_h, tx_h_valid, tx_k_g, tx_g_valid;
    wire rx_in_ready, rx_clock_ch_h, rx_clock_ch_g, per_channel_rx_clock_a, per_channel_rx_clock_b;
    wire rx_ab_bit8_kflag, rx_ab_bit9;
    wire [7:0] tx_gh_bus, rx_ab_bus;
    wire [9:0] tx_word_h, tx_word_g;
    wire [9:0] pins = {rx_ab_bit9, rx_ab_bit8_kflag, rx_ab_bus};
    integer miscompares = 0, checks = 0, cyc = 0, cnt, cnt_a;
    localparam [9:0] NA = 10'h335, NB = 10'h2CA;
    ddr_parallel_data_port u_dut (.ref_clk, .rstn, .if_mode, .code_en, .clock_tolerance_fifo,
        .tx_clock_ch_b, .tx_clock_ch_h, .tx_gh_bus, .tx_gh_bit8_kind, .tx_gh_bit9, .tx_word_h, .tx_k_h,
        .tx_h_valid, .tx_word_g, .tx_k_g, .tx_g_valid, .recovered_clock, .rx_in_valid, .rx_in_ready,
        .rx_word_a, .rx_k_a, .rx_word_b, .rx_k_b, .rx_clock_ch_h, .rx_clock_ch_g, .per_channel_rx_clock_a,
        .per_channel_rx_clock_b, .rx_ab_bus, .rx_ab_bit8_kflag, .rx_ab_bit9);
    mac_tx_model u_mac (.code_en, .tx_clock_ch_b, .tx_clock_ch_h, .tx_gh_bus, .tx_gh_bit8_kind, .tx_gh_bit9);
    // reference clock, 10 ns
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // watchdog: the sequence needs about 1800 cycles
    always @(posedge ref_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            miscompares = miscompares + 1;
            report_and_stop;
        end
    end
    // ----
    // tasks
    // ----
    task cmp(input [10:0] got, input [10:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // word as seen with the coder on: k flag beside the byte
    function [9:0] coded(input k, input [9:0] w);
        coded = code_en ? {1'b0, k, w[7:0]} : w;
    endfunction
    // configuration only moves with the path idle
    task cfg(input [1:0] m, input c, input f);
    begin
        @(negedge ref_clk);
        if_mode = m;
        code_en = c;
        clock_tolerance_fifo = f;
        repeat (10) @(negedge ref_clk);
    end
    endtask
    // one frame from the far side, checked while the valid pulse stands
    // g and h are the pin values placed before each edge, eg and eh the words that must arrive
    task tx_case(input indep, input [9:0] g, input [9:0] h, input [9:0] eg, input [9:0] eh);
    begin
        cnt = 0;
        fork
            u_mac.frame(indep, g, h);
            begin
                while (tx_h_valid !== 1'b1 && cnt < 40)
                begin
                    @(negedge ref_clk);
                    cnt = cnt + 1;
                end
                cmp({tx_h_valid, coded(tx_k_h, tx_word_h)}, {1'b1, coded(eh[8], eh)});
                if (!indep)
                    cmp({tx_g_valid, coded(tx_k_g, tx_word_g)}, {1'b1, coded(eg[8], eg)});
            end
        join
    end
    endtask
    // push one pair, then find the falling half and the rising half after it
    task rx_case(input [21:0] pair, input [9:0] fe, input [9:0] re);
    begin
        @(negedge ref_clk);
        {rx_k_b, rx_word_b, rx_k_a, rx_word_a} = pair;
        rx_in_valid = 1'b1;
        @(negedge ref_clk);
        rx_in_valid = 1'b0;
        cnt = 0;
        while (!(rx_clock_ch_h === 1'b0 && pins === fe) && cnt < 40)
        begin
            @(negedge ref_clk);
            cnt = cnt + 1;
        end
        cmp({rx_clock_ch_h, pins}, {1'b0, fe});
        @(negedge ref_clk);
        cmp({rx_clock_ch_h, pins}, {1'b1, re});
    end
    endtask
    task report_and_stop;
    begin
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    // ----
    // main sequence
    // ----
    initial
    begin
        rstn = 1'b0;
        if_mode = `MODE_MUX;
        code_en = 1'b1;
        clock_tolerance_fifo = 1'b1;
        recovered_clock = 1'b0;
        rx_in_valid = 1'b0;
        {rx_k_b, rx_word_b, rx_k_a, rx_word_a} = 22'h000000;
        repeat (10) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (10) @(negedge ref_clk);
        tx_case(1'b0, 10'h2A5, 10'h1BC, 10'h2A5, 10'h1BC);
        rx_case({1'b0, 10'h055, 1'b1, 10'h03C}, 10'h13C, 10'h055);
        rx_case({1'b1, 10'h0BC, 1'b0, 10'h0F7}, 10'h0F7, 10'h1BC);
        cfg(`MODE_MUX, 1'b0, 1'b1);
        tx_case(1'b0, 10'h2A5, 10'h35A, 10'h2A5, 10'h35A);
        rx_case({1'b0, 10'h15A, 1'b0, 10'h2A5}, 10'h2A5, 10'h15A);
        cfg(`MODE_INDEP, 1'b0, 1'b1);
        tx_case(1'b1, 10'h000, 10'h3C3, 10'h000, 10'h3C3);
        cfg(`MODE_NIBBLE, 1'b0, 1'b1);
        // nibble lanes: G on 4:0, H on 9:5, low halves before the falling edge
        tx_case(1'b0, {NB[4:0], NA[4:0]}, {NB[9:5], NA[9:5]}, NA, NB);
        rx_case({1'b0, NB, 1'b0, NA}, {NB[4:0], NA[4:0]}, {NB[9:5], NA[9:5]});
        // divided clock frozen: nothing drains, so the buffer fills and refuses
        cfg(`MODE_NIBBLE, 1'b0, 1'b0);
        rx_in_valid = 1'b1;
        repeat (`FIFO_DEPTH) @(negedge ref_clk);
        rx_in_valid = 1'b0;
        cmp({10'h000, rx_in_ready}, 11'h000);
        last = rx_clock_ch_h;
        last_a = per_channel_rx_clock_a;
        cnt_a = 0;
        cnt = 0;
        // recovered clock toggles on falling reference edges, 160 ns period
        fork
            repeat (200) #80 recovered_clock = ~recovered_clock;
            repeat (1600)
            begin
                @(negedge ref_clk);
                if (rx_clock_ch_h !== last)
                    cnt = cnt + 1;
                if (per_channel_rx_clock_a !== last_a)
                    cnt_a = cnt_a + 1;
                last = rx_clock_ch_h;
                last_a = per_channel_rx_clock_a;
            end
        join
        cmp({10'h000, (cnt >= 19) && (cnt <= 21)}, 11'h001);
        cmp({10'h000, (cnt_a >= 19) && (cnt_a <= 21)}, 11'h001);
        cmp({10'h000, rx_in_ready}, 11'h001);
        report_and_stop;
    end
endmodule
bind ddr_parallel_data_port ddr_port_checker u_chk (.ref_clk, .rstn, .if_mode, .code_en, .clock_tolerance_fifo,
    .tx_word_h, .tx_h_valid, .rx_clock_ch_h, .rx_clock_ch_g, .per_channel_rx_clock_a, .per_channel_rx_clock_b,
    .rx_ab_bus, .rx_ab_bit9);
